// [hdl/lm_adc_ctrl.sv]
// Line monitor converter control: trigger handling, timing, result and bus slave.
// Assumes trigger and comparator arrive asynchronously from pins; AXI4-Lite master on aclk.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Result is a 7-bit successive-approximation code from 0 to 127.
// - One step is 19.5 mV; the MSB carries the 1.25 V reference weight.
// - Controller raises the trigger; converter stays reset while it is high.
// - Done asserts 50 us after the trigger falls.
// - With the done mask bit set, each rising edge of done raises the interrupt output.
// - Controller reads the result over the bus after the interrupt.
// - Four-bit selector routes one of the listed sources; other codes unused.
// - Range bit high halves the line-current scale factor, halving the range.
// - Level detector readings are eight times peak minus a prior reference.
module lm_adc_ctrl
  import lm_pkg::*;
#(
  parameter int unsigned CONV_CYCLES = LM_CONV_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic conv_trigger,
  input wire logic comparator_high,
  output logic converter_reset,
  output logic [6:0] dac_trial_code,
  output logic conv_done,
  output logic irq,
  output logic [3:0] adc_source_sel,
  output logic current_range_halve,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  localparam int unsigned TW = $clog2(CONV_CYCLES + 1);
  localparam logic [TW-1:0] TIMER_LAST = TW'(CONV_CYCLES - 1);

  lm_sar_if sar ();

  lm_sar_core #(
    .STEP_CYCLES(CONV_CYCLES / LM_STEPS)
  ) u_core (
    .aclk(aclk),
    .aresetn(aresetn),
    .sar(sar.core)
  );

  // Pin synchronisers
  logic trig_s1_q;
  logic trig_s2_q;
  logic cmp_s1_q;
  logic cmp_s2_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trig_s1_q <= 1'b0;
      trig_s2_q <= 1'b0;
      cmp_s1_q <= 1'b0;
      cmp_s2_q <= 1'b0;
    end else begin
      trig_s1_q <= conv_trigger;
      trig_s2_q <= trig_s1_q;
      cmp_s1_q <= comparator_high;
      cmp_s2_q <= cmp_s1_q;
    end
  end

  // Conversion sequencing
  lm_phase_e phase_q;
  lm_phase_e phase_d;
  logic [TW-1:0] timer_q;
  logic conv_reset_q;
  logic start_q;
  logic done_q;
  logic ev_done;
  logic ev_abort;

  always_comb begin
    phase_d = phase_q;
    unique case (phase_q)
      LM_PH_IDLE: begin
        if (trig_s2_q) begin
          phase_d = LM_PH_RESET;
        end
      end
      LM_PH_RESET: begin
        if (!trig_s2_q) begin
          phase_d = LM_PH_CONVERT;
        end
      end
      LM_PH_CONVERT: begin
        if (trig_s2_q) begin
          phase_d = LM_PH_RESET;
        end else if (timer_q == TIMER_LAST) begin
          phase_d = LM_PH_DONE;
        end
      end
      LM_PH_DONE: begin
        if (trig_s2_q) begin
          phase_d = LM_PH_RESET;
        end
      end
    endcase
  end

  assign ev_done = (phase_d == LM_PH_DONE) && !done_q;
  assign ev_abort = (phase_q == LM_PH_CONVERT) && trig_s2_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_q <= LM_PH_IDLE;
      timer_q <= '0;
      conv_reset_q <= 1'b1;
      start_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      phase_q <= phase_d;
      if (phase_q == LM_PH_CONVERT) begin
        timer_q <= timer_q + TW'(1);
      end else begin
        timer_q <= '0;
      end
      conv_reset_q <= (phase_d == LM_PH_RESET) || (phase_d == LM_PH_IDLE);
      start_q <= (phase_q == LM_PH_RESET) && (phase_d == LM_PH_CONVERT);
      done_q <= (phase_d == LM_PH_DONE);
    end
  end

  assign sar.clear = conv_reset_q;
  assign sar.start = start_q;
  assign sar.cmp = cmp_s2_q;

  // Control, result and level-detector registers
  logic [5:0] ctrl_q;
  logic [1:0] mask_q;
  logic [1:0] irq_stat_q;
  logic [1:0] irq_stat_d;
  logic irq_q;
  logic [3:0] conv_sel_q;
  logic conv_halve_q;
  logic [6:0] result_q;
  logic result_valid_q;
  logic [31:0] scaled_q;
  logic [6:0] ref_q;
  logic [10:0] diff_q;
  logic wr_fire;
  logic [7:0] wr_addr_q;
  logic [31:0] wr_data_q;
  logic [3:0] wr_strb_q;
  logic rd_clear;

  function automatic logic source_unused(input logic [3:0] sel);
    unique case (sel)
      4'h8, 4'hD, 4'hE, 4'hF: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : source_unused

  function automatic logic is_level(input logic [3:0] sel);
    return (sel == LM_SRC_RECEIVE_LEVEL_DETECTOR) || (sel == LM_SRC_TRANSMIT_LEVEL_DETECTOR);
  endfunction : is_level

  // Physical value of a code: microamps for line current, microvolts for external input, supply nodes and speaker output, zero otherwise
  function automatic logic [31:0] scale_code(input logic [3:0] sel, input logic halve,
                                             input logic [6:0] d);
    logic [31:0] fs;
    logic [31:0] prod;
    fs = 32'h0;
    unique case (sel)
      LM_SRC_LINE_CURRENT: fs = LM_FS_LINE_UA;
      LM_SRC_EXTERNAL_ANALOG_INPUT: fs = LM_FS_EXT_UV;
      LM_SRC_SUPPLY_NODE_B, LM_SRC_SUPPLY_NODE_MPS, LM_SRC_SUPPLY_NODE_MP,
      LM_SRC_SPEAKER_AMP_OUTPUT: fs = LM_FS_SUPPLY_UV;
      default: fs = 32'h0;
    endcase
    prod = fs * {25'h0, d};
    if (sel == LM_SRC_LINE_CURRENT && halve) begin
      return prod >> (LM_DIV_SHIFT + 1);
    end
    return prod >> LM_DIV_SHIFT;
  endfunction : scale_code

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= LM_CTRL_RST;
      mask_q <= LM_MASK_RST;
    end else if (wr_fire) begin
      if (wr_addr_q == LM_ADDR_CTRL) begin
        ctrl_q <= LM_CTRL_W'(lm_merge({26'h0, ctrl_q}, wr_data_q, wr_strb_q));
      end
      if (wr_addr_q == LM_ADDR_MASK) begin
        mask_q <= LM_IRQ_W'(lm_merge({30'h0, mask_q}, wr_data_q, wr_strb_q));
      end
    end
  end

  // Source and range are captured when the trigger resets the converter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      conv_sel_q <= LM_SRC_OFF;
      conv_halve_q <= 1'b0;
    end else if (phase_d == LM_PH_RESET) begin
      conv_sel_q <= ctrl_q[LM_CTRL_SEL_LSB +: 4];
      conv_halve_q <= ctrl_q[LM_CTRL_RANGE_BIT];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result_q <= 7'h00;
      result_valid_q <= 1'b0;
      scaled_q <= 32'h0;
    end else if (phase_d == LM_PH_RESET) begin
      result_valid_q <= 1'b0;
    end else if (ev_done) begin
      result_q <= sar.result;
      result_valid_q <= 1'b1;
      scaled_q <= scale_code(conv_sel_q, conv_halve_q, sar.result);
    end
  end

  // Reference capture or eight-fold difference for the level detectors
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ref_q <= 7'h00;
      diff_q <= 11'h000;
    end else if (ev_done && is_level(conv_sel_q)) begin
      if (ctrl_q[LM_CTRL_REFCAP_BIT]) begin
        ref_q <= sar.result;
      end else begin
        diff_q <= 11'(({4'h0, sar.result} - {4'h0, ref_q}) << LM_LEVEL_SHIFT);
      end
    end
  end

  // Sticky events, cleared by a read of the status register; a new event wins
  always_comb begin
    irq_stat_d = rd_clear ? 2'h0 : irq_stat_q;
    if (ev_done) begin
      irq_stat_d[LM_IRQ_DONE_BIT] = 1'b1;
    end
    if (ev_abort) begin
      irq_stat_d[LM_IRQ_ABORT_BIT] = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_q <= 2'h0;
      irq_q <= 1'b0;
    end else begin
      irq_stat_q <= irq_stat_d;
      irq_q <= |(irq_stat_d & mask_q);
    end
  end

  // AXI4-Lite write channel
  logic aw_have_q;
  logic w_have_q;
  logic awready_q;
  logic wready_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic aw_take;
  logic w_take;
  logic aw_have_d;
  logic w_have_d;
  logic bvalid_d;
  logic wr_mapped;

  assign aw_take = s_axi_awvalid && awready_q;
  assign w_take = s_axi_wvalid && wready_q;
  assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
  assign aw_have_d = (aw_have_q || aw_take) && !wr_fire;
  assign w_have_d = (w_have_q || w_take) && !wr_fire;
  assign bvalid_d = wr_fire || (bvalid_q && !s_axi_bready);
  assign wr_mapped = (wr_addr_q == LM_ADDR_CTRL) || (wr_addr_q == LM_ADDR_MASK);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= LM_RESP_OKAY;
      wr_addr_q <= 8'h00;
      wr_data_q <= 32'h0;
      wr_strb_q <= 4'h0;
    end else begin
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      awready_q <= !aw_have_d && !bvalid_d;
      wready_q <= !w_have_d && !bvalid_d;
      bvalid_q <= bvalid_d;
      if (aw_take) begin
        wr_addr_q <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (w_take) begin
        wr_data_q <= s_axi_wdata;
        wr_strb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        bresp_q <= wr_mapped ? LM_RESP_OKAY : LM_RESP_SLVERR;
      end
    end
  end

  // AXI4-Lite read channel
  logic arready_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic ar_take;
  logic rvalid_d;
  logic [7:0] rd_addr;
  logic [31:0] rd_word;
  logic rd_ok;

  assign ar_take = s_axi_arvalid && arready_q;
  assign rvalid_d = ar_take || (rvalid_q && !s_axi_rready);
  assign rd_addr = {s_axi_araddr[7:2], 2'b00};
  assign rd_clear = ar_take && (rd_addr == LM_ADDR_STATUS);

  always_comb begin
    rd_word = 32'h0;
    rd_ok = 1'b1;
    unique case (rd_addr)
      LM_ADDR_CTRL: rd_word[LM_CTRL_W-1:0] = ctrl_q;
      LM_ADDR_STATUS: begin
        rd_word[LM_IRQ_W-1:0] = irq_stat_q;
        rd_word[LM_STAT_PHASE_LSB +: 2] = phase_q;
        rd_word[LM_STAT_TRIG_BIT] = trig_s2_q;
      end
      LM_ADDR_MASK: rd_word[LM_IRQ_W-1:0] = mask_q;
      LM_ADDR_RESULT: begin
        rd_word[LM_RES_W-1:0] = result_q;
        rd_word[LM_RES_VALID_BIT] = result_valid_q;
        rd_word[LM_RES_UNUSED_BIT] = source_unused(conv_sel_q);
        rd_word[LM_RES_SEL_LSB +: 4] = conv_sel_q;
      end
      LM_ADDR_SCALED: rd_word = scaled_q;
      LM_ADDR_REF: rd_word[LM_RES_W-1:0] = ref_q;
      LM_ADDR_DIFF: rd_word = {{21{diff_q[10]}}, diff_q};
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= LM_RESP_OKAY;
    end else begin
      arready_q <= !rvalid_d;
      rvalid_q <= rvalid_d;
      if (ar_take) begin
        rdata_q <= rd_word;
        rresp_q <= rd_ok ? LM_RESP_OKAY : LM_RESP_SLVERR;
      end
    end
  end

  // Outputs
  assign converter_reset = conv_reset_q;
  assign dac_trial_code = sar.trial;
  assign conv_done = done_q;
  assign irq = irq_q;
  assign adc_source_sel = ctrl_q[LM_CTRL_SEL_LSB +: 4];
  assign current_range_halve = ctrl_q[LM_CTRL_RANGE_BIT];
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

endmodule : lm_adc_ctrl
`default_nettype wire

// [hdl/lm_pkg.sv]
// Shared constants and types of the line monitor converter control.
// Assumes a single 125 MHz clock and an AXI4-Lite register bus with 32-bit data.
package lm_pkg;

  // Clock rate and conversion timing
  localparam int unsigned LM_CLK_MHZ = 125;
  localparam int unsigned LM_CONV_TIME_US = 50;
  localparam int unsigned LM_CONV_CYCLES = LM_CONV_TIME_US * LM_CLK_MHZ;
  localparam int unsigned LM_STEPS = 8;
  localparam int unsigned LM_STEP_CYCLES = LM_CONV_CYCLES / LM_STEPS;

  // Result width and analog weights in microvolts
  localparam int unsigned LM_RES_W = 7;
  localparam int unsigned LM_LSB_UV = 19500;
  localparam int unsigned LM_MSB_REF_UV = 1250000;
  localparam logic [6:0] LM_MSB_CODE = 7'h40;

  // Full-scale values per code, scaled by 128
  localparam logic [31:0] LM_FS_LINE_UA = 32'h0001_F018;
  localparam logic [31:0] LM_FS_EXT_UV = 32'h0026_25A0;
  localparam logic [31:0] LM_FS_SUPPLY_UV = 32'h005F_5E10;
  localparam int unsigned LM_DIV_SHIFT = 7;
  localparam int unsigned LM_LEVEL_SHIFT = 3;

  // Register byte offsets
  localparam logic [7:0] LM_ADDR_CTRL = 8'h00;
  localparam logic [7:0] LM_ADDR_STATUS = 8'h04;
  localparam logic [7:0] LM_ADDR_MASK = 8'h08;
  localparam logic [7:0] LM_ADDR_RESULT = 8'h0C;
  localparam logic [7:0] LM_ADDR_SCALED = 8'h10;
  localparam logic [7:0] LM_ADDR_REF = 8'h14;
  localparam logic [7:0] LM_ADDR_DIFF = 8'h18;

  // Field positions
  localparam int unsigned LM_CTRL_SEL_LSB = 0;
  localparam int unsigned LM_CTRL_RANGE_BIT = 4;
  localparam int unsigned LM_CTRL_REFCAP_BIT = 5;
  localparam int unsigned LM_CTRL_W = 6;
  localparam int unsigned LM_IRQ_DONE_BIT = 0;
  localparam int unsigned LM_IRQ_ABORT_BIT = 1;
  localparam int unsigned LM_IRQ_W = 2;
  localparam int unsigned LM_RES_VALID_BIT = 8;
  localparam int unsigned LM_RES_UNUSED_BIT = 9;
  localparam int unsigned LM_RES_SEL_LSB = 12;
  localparam int unsigned LM_STAT_PHASE_LSB = 8;
  localparam int unsigned LM_STAT_TRIG_BIT = 10;

  // Values after reset
  localparam logic [5:0] LM_CTRL_RST = 6'h00;
  localparam logic [1:0] LM_MASK_RST = 2'h0;

  // AXI response codes
  localparam logic [1:0] LM_RESP_OKAY = 2'h0;
  localparam logic [1:0] LM_RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    LM_SRC_OFF = 4'h0,
    LM_SRC_LINE_CURRENT = 4'h1,
    LM_SRC_EXTERNAL_ANALOG_INPUT = 4'h2,
    LM_SRC_SUPPLY_NODE_B = 4'h3,
    LM_SRC_SUPPLY_NODE_MPS = 4'h4,
    LM_SRC_SUPPLY_NODE_MP = 4'h5,
    LM_SRC_RECEIVE_LEVEL_DETECTOR = 4'h6,
    LM_SRC_TRANSMIT_LEVEL_DETECTOR = 4'h7,
    LM_SRC_SPEAKER_AMP_OUTPUT = 4'h9,
    LM_SRC_OFFSET_CANCEL_PROBE_ONE = 4'hA,
    LM_SRC_OFFSET_CANCEL_PROBE_TWO = 4'hB,
    LM_SRC_OFFSET_CANCEL_PROBE_THREE = 4'hC
  } lm_src_e;

  typedef enum logic [1:0] {
    LM_PH_IDLE = 2'b00,
    LM_PH_RESET = 2'b01,
    LM_PH_CONVERT = 2'b10,
    LM_PH_DONE = 2'b11
  } lm_phase_e;

  // Applies AXI byte enables to a register word
  function automatic logic [31:0] lm_merge(input logic [31:0] old_w, input logic [31:0] new_w,
                                           input logic [3:0] strb);
    logic [31:0] res;
    res = old_w;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    return res;
  endfunction : lm_merge

endpackage : lm_pkg

// [hdl/lm_sar_core.sv]
// Successive-approximation register: one bit decided per step, MSB first.
// Assumes a synchronised comparator level, high while input is at or above the trial code.
`timescale 1ns/1ps
`default_nettype none
module lm_sar_core
  import lm_pkg::*;
#(
  parameter int unsigned STEP_CYCLES = LM_STEP_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  lm_sar_if.core sar
);

  localparam int unsigned SW = $clog2(STEP_CYCLES + 1);
  localparam logic [SW-1:0] STEP_LAST = SW'(STEP_CYCLES - 1);

  logic [SW-1:0] step_q;
  logic [2:0] bit_q;
  logic [6:0] trial_q;
  logic [6:0] result_q;
  logic busy_q;
  logic fin_q;
  logic [6:0] kept;

  // Trial bit is dropped when the comparator says the input lies below it
  assign kept = sar.cmp ? trial_q : (trial_q & ~(7'h01 << bit_q));

  always_ff @(posedge aclk) begin
    if (!aresetn || sar.clear) begin
      step_q <= '0;
      bit_q <= 3'h0;
      trial_q <= 7'h00;
      result_q <= 7'h00;
      busy_q <= 1'b0;
      fin_q <= 1'b0;
    end else if (sar.start) begin
      step_q <= '0;
      bit_q <= 3'h6;
      trial_q <= LM_MSB_CODE;
      busy_q <= 1'b1;
      fin_q <= 1'b0;
    end else if (busy_q) begin
      if (step_q == STEP_LAST) begin
        step_q <= '0;
        if (bit_q == 3'h0) begin
          trial_q <= kept;
          result_q <= kept;
          busy_q <= 1'b0;
          fin_q <= 1'b1;
        end else begin
          trial_q <= kept | (7'h01 << (bit_q - 3'h1));
          bit_q <= bit_q - 3'h1;
        end
      end else begin
        step_q <= step_q + SW'(1);
      end
    end
  end

  assign sar.trial = trial_q;
  assign sar.result = result_q;
  assign sar.busy = busy_q;
  assign sar.finished = fin_q;

endmodule : lm_sar_core
`default_nettype wire

// [hdl/lm_sar_if.sv]
// Link between the conversion controller and the approximation core.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface lm_sar_if;
  logic clear;
  logic start;
  logic cmp;
  logic [6:0] trial;
  logic [6:0] result;
  logic busy;
  logic finished;

  modport ctrl (output clear, output start, output cmp,
                input trial, input result, input busy, input finished);
  modport core (input clear, input start, input cmp,
                output trial, output result, output busy, output finished);
endinterface : lm_sar_if
`default_nettype wire

// [testbench/lm_adc_ctrl_checker.sv]
// Concurrent checks on the converter control ports.
// Assumes binding to lm_adc_ctrl with its conversion length parameter.
`timescale 1ns/1ps
`default_nettype none
module lm_adc_ctrl_checker
  import lm_pkg::*;
#(
  parameter int unsigned CONV_CYCLES = LM_CONV_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic conv_trigger,
  input wire logic converter_reset,
  input wire logic [6:0] dac_trial_code,
  input wire logic conv_done,
  input wire logic irq,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid
);
  localparam int unsigned LIM = CONV_CYCLES + 16;
  logic armed_q;
  logic [15:0] low_cnt_q;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Cycles since the trigger pin was last seen high
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      armed_q <= 1'b0;
      low_cnt_q <= 16'h0000;
    end else if (conv_trigger) begin
      armed_q <= 1'b1;
      low_cnt_q <= 16'h0000;
    end else if (armed_q && low_cnt_q < LIM) begin
      low_cnt_q <= low_cnt_q + 16'h0001;
    end
  end

  AST_TRIG_RESETS: assert property (conv_trigger [*5] |-> converter_reset)
    else $error("no reset under trigger");
  AST_TRIG_CLEARS_DONE: assert property (conv_trigger [*5] |-> !conv_done)
    else $error("done under trigger");
  AST_DONE_NOT_RESET: assert property ($rose(conv_done) |-> !converter_reset)
    else $error("done in reset");
  AST_DONE_EARLY: assert property ($rose(conv_done) |-> armed_q && low_cnt_q >= CONV_CYCLES)
    else $error("done early");
  AST_DONE_LATE: assert property (armed_q && !conv_trigger && low_cnt_q == CONV_CYCLES + 8
    |-> conv_done) else $error("done late");
  AST_RESULT_HELD: assert property (conv_done && $past(conv_done) |-> $stable(dac_trial_code))
    else $error("result moved");
  AST_B_TIMING: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("bvalid late");
  AST_R_TIMING: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("rvalid late");
  AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("arready during rvalid");
  AST_AW_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("ready during bvalid");

  cover property ($rose(conv_done));
  cover property ($rose(irq));
  cover property (s_axi_bvalid && s_axi_bresp == LM_RESP_SLVERR);
endmodule : lm_adc_ctrl_checker

bind lm_adc_ctrl lm_adc_ctrl_checker #(.CONV_CYCLES(CONV_CYCLES)) u_chk (.aclk, .aresetn,
  .conv_trigger, .converter_reset, .dac_trial_code, .conv_done, .irq, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid);
`default_nettype wire

// [testbench/lm_analog_model.sv]
// Analog front end model: comparator against the converter's trial code.
// Assumes the testbench sets the analog level as an equivalent 7-bit code.
`timescale 1ns/1ps
`default_nettype none
module lm_analog_model (
  input wire logic [6:0] dac_trial_code,
  input wire logic [6:0] level_code,
  output logic comparator_high
);
  // Input at or above the trial code keeps that trial bit
  assign comparator_high = (level_code >= dac_trial_code);
endmodule : lm_analog_model
`default_nettype wire

// [testbench/tb_lm_adc_ctrl.sv]
// Self-checking bench for the converter control: AXI4-Lite master and trigger pin.
// Assumes a short conversion length and the analog model on the comparator pin.
`timescale 1ns/1ps
`default_nettype none
module tb_lm_adc_ctrl;
  import lm_pkg::*;
  localparam int unsigned CONV = 64;
  logic aclk, aresetn, conv_trigger, comparator_high, converter_reset, conv_done, irq;
  logic current_range_halve, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [6:0] dac_trial_code, level_code;
  logic [3:0] adc_source_sel, s_axi_wstrb;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int miscompares = 0;
  int n_tests = 0;

  lm_adc_ctrl #(.CONV_CYCLES(CONV)) dut_u (.aclk, .aresetn, .conv_trigger, .comparator_high,
    .converter_reset, .dac_trial_code, .conv_done, .irq, .adc_source_sel, .current_range_halve,
    .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);
  lm_analog_model model_u (.dac_trial_code, .level_code, .comparator_high);

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : complete_run

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic w(input logic [7:0] a, input logic [31:0] d,
                   input logic [1:0] er = LM_RESP_OKAY);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && s_axi_awready) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    check("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
  endtask : w

  task automatic rv(input logic [7:0] a, output logic [31:0] d,
                    input logic [1:0] er = LM_RESP_OKAY);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    check("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
  endtask : rv

  // Pulses the trigger, then counts edges until done is seen
  task automatic convert(input logic [6:0] v, output int cyc);
    level_code <= v;
    conv_trigger <= 1'b1;
    repeat (4) @(posedge aclk);
    conv_trigger <= 1'b0;
    cyc = 0;
    do begin
      @(posedge aclk);
      cyc++;
    end while (!conv_done && cyc < 300);
  endtask : convert

  task automatic t_regs();
    logic [31:0] d;
    rv(LM_ADDR_CTRL, d);
    check("ctrl reset", d, 32'h0);
    rv(LM_ADDR_MASK, d);
    check("mask reset", d, 32'h0);
    w(8'h40, 32'h1, LM_RESP_SLVERR);
    rv(8'h40, d, LM_RESP_SLVERR);
    check("unmapped rdata", d, 32'h0);
    w(LM_ADDR_RESULT, 32'h7F, LM_RESP_SLVERR);
    w(LM_ADDR_CTRL, 32'h0000_003F);
    rv(LM_ADDR_CTRL, d);
    check("ctrl rw", d, 32'h0000_003F);
    check("range pin", {31'h0, current_range_halve}, 32'h0000_0001);
  endtask : t_regs

  task automatic t_sel();
    for (int i = 0; i < 16; i++) begin
      w(LM_ADDR_CTRL, i);
      @(posedge aclk);
      check("source sel", {28'h0, adc_source_sel}, i);
    end
  endtask : t_sel

  task automatic t_conv();
    logic [31:0] d, e;
    logic [3:0] s;
    logic h;
    logic [6:0] v;
    int c;
    for (int k = 0; k < 7; k++) begin
      case (k)
        0: begin s = 4'h1; h = 1'b0; v = 7'h40; e = 32'd63500; end
        1: begin s = 4'h1; h = 1'b1; v = 7'h40; e = 32'd31750; end
        2: begin s = 4'h2; h = 1'b0; v = 7'h40; e = LM_MSB_REF_UV; end
        3: begin s = 4'h3; h = 1'b0; v = 7'h20; e = 32'd1562500; end
        4: begin s = 4'h9; h = 1'b0; v = 7'h20; e = 32'd1562500; end
        5: begin s = 4'h0; h = 1'b0; v = 7'h7F; e = 32'h0; end
        default: begin s = 4'h5; h = 1'b0; v = 7'h00; e = 32'h0; end
      endcase
      w(LM_ADDR_CTRL, {27'h0, h, s});
      w(LM_ADDR_MASK, 32'h0000_0001);
      convert(v, c);
      check("done time ok", c >= CONV && c <= CONV + 8, 32'h1);
      check("irq at done", {31'h0, irq}, 32'h1);
      check("trial code", {25'h0, dac_trial_code}, {25'h0, v});
      rv(LM_ADDR_RESULT, d);
      check("result code", {25'h0, d[6:0]}, {25'h0, v});
      check("result valid", {31'h0, d[8]}, 32'h1);
      check("result source", {28'h0, d[15:12]}, {28'h0, s});
      rv(LM_ADDR_SCALED, d);
      check("scaled", d, e);
      rv(LM_ADDR_STATUS, d);
      check("status event", {30'h0, d[1:0]}, 32'h1);
      rv(LM_ADDR_STATUS, d);
      check("status cleared", {30'h0, d[1:0]}, 32'h0);
      check("irq cleared", {31'h0, irq}, 32'h0);
    end
  endtask : t_conv

  task automatic t_level();
    logic [31:0] d;
    int c;
    w(LM_ADDR_CTRL, 32'h0000_0026);
    convert(7'd20, c);
    rv(LM_ADDR_REF, d);
    check("reference", d, 32'h0000_0014);
    w(LM_ADDR_CTRL, 32'h0000_0006);
    convert(7'd30, c);
    rv(LM_ADDR_DIFF, d);
    check("diff positive", d, 32'h0000_0050);
    w(LM_ADDR_CTRL, 32'h0000_0007);
    convert(7'd15, c);
    rv(LM_ADDR_DIFF, d);
    check("diff negative", d, 32'hFFFF_FFD8);
  endtask : t_level

  task automatic t_hold();
    logic [31:0] d;
    int c;
    w(LM_ADDR_CTRL, 32'h0000_0002);
    convert(7'h63, c);
    repeat (40) @(posedge aclk);
    rv(LM_ADDR_RESULT, d);
    check("held result", {23'h0, d[8:0]}, 32'h0000_0163);
    check("done held", {31'h0, conv_done}, 32'h1);
    conv_trigger <= 1'b1;
    repeat (6) @(posedge aclk);
    check("conv reset", {31'h0, converter_reset}, 32'h1);
    check("done dropped", {31'h0, conv_done}, 32'h0);
    rv(LM_ADDR_RESULT, d);
    check("value kept", {23'h0, d[8:0]}, 32'h0000_0063);
  endtask : t_hold

  task automatic t_abort();
    logic [31:0] d;
    w(LM_ADDR_MASK, 32'h0000_0002);
    rv(LM_ADDR_STATUS, d);
    conv_trigger <= 1'b0;
    repeat (20) @(posedge aclk);
    conv_trigger <= 1'b1;
    repeat (80) @(posedge aclk);
    check("no done on abort", {31'h0, conv_done}, 32'h0);
    check("abort irq", {31'h0, irq}, 32'h1);
    rv(LM_ADDR_STATUS, d);
    check("abort event", {30'h0, d[1:0]}, 32'h2);
    rv(LM_ADDR_STATUS, d);
    check("abort cleared", {30'h0, d[1:0]}, 32'h0);
    check("irq low", {31'h0, irq}, 32'h0);
  endtask : t_abort

  initial begin
    aresetn = 1'b0;
    conv_trigger = 1'b0;
    level_code = 7'h00;
    s_axi_awaddr = 8'h00;
    s_axi_awprot = 3'h0;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hF;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b1;
    s_axi_araddr = 8'h00;
    s_axi_arprot = 3'h0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b1;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_sel();
    t_conv();
    t_level();
    t_hold();
    t_abort();
    complete_run();
  end

  // Ends a hung run
  initial begin
    repeat (30000) @(posedge aclk);
    miscompares++;
    complete_run();
  end
endmodule : tb_lm_adc_ctrl
`default_nettype wire
